//--- src/ats_pkg.sv
// Shared constants for the transmit scheduler
package ats_pkg;
  // ==========================================================
  // Channels and tables
  localparam int unsigned NUM_TX     = 4;
  localparam int unsigned NUM_RX     = 8;
  localparam int unsigned NUM_DESC   = 256;
  localparam int unsigned WORD_BYTES = 4;
  localparam logic [15:0] TBL_BASE   = 16'h4000;
  localparam logic [2:0]  TBL_REGION = 3'b010;
  localparam int unsigned TBL_AW     = 13;
  localparam int unsigned RX_AW      = 11;
  localparam logic [7:0]  DESC_LAST  = 8'hff;
  localparam logic [1:0]  BYTE_LAST  = 2'h3;
  localparam logic [3:0]  FLAGS_ALL  = 4'hf;

  // ==========================================================
  // Action codes: top three bits select the class
  localparam logic [7:0] ACT_EOS      = 8'h00;
  localparam logic [7:0] ACT_IMM      = 8'h40;
  localparam logic [2:0] CLS_EOS      = 3'h0;
  localparam logic [2:0] CLS_ZERO     = 3'h1;
  localparam logic [2:0] CLS_IMM      = 3'h2;
  localparam logic [2:0] CLS_IDX      = 3'h4;
  localparam logic [2:0] CLS_IDC      = 3'h5;
  localparam logic [2:0] CLS_IDC_PEEK = 3'h6;
  localparam int unsigned ACT_CLS_LSB = 5;
  localparam int unsigned ACT_RXC_LSB = 2;

  // ==========================================================
  // Timing
  localparam int unsigned CLK_HZ       = 125_000_000;
  localparam int unsigned BASE_TICK_US = 10_000;
  localparam int unsigned BASE_TICK_CYC = (CLK_HZ / 1_000_000) * BASE_TICK_US;
  localparam int unsigned TICK_W       = 21;
  localparam int unsigned RATE_W       = 8;

  // ==========================================================
  // Sequencer states, Gray ordered along the usual path
  typedef enum logic [2:0] {
    ATS_IDLE    = 3'b000,
    ATS_FETCH_A = 3'b001,
    ATS_GOT_A   = 3'b011,
    ATS_GOT_V   = 3'b010,
    ATS_GOT_R   = 3'b110,
    ATS_SEND    = 3'b111
  } ats_state_e;
endpackage : ats_pkg

//--- src/ats_rx_if.sv
// Fetch port between the sequencer and received-message memory
`timescale 1ns/1ns
interface ats_rx_if;
  logic       rd_en;
  logic [2:0] rd_chan;
  logic [7:0] rd_label;
  logic [1:0] rd_byte;
  logic       clr_en;
  logic [1:0] clr_tx;
  logic [7:0] rd_data;
  logic       rd_flag;

  modport sched (output rd_en, rd_chan, rd_label, rd_byte, clr_en, clr_tx,
                 input rd_data, rd_flag);
  modport mem   (input rd_en, rd_chan, rd_label, rd_byte, clr_en, clr_tx,
                 output rd_data, rd_flag);
endinterface : ats_rx_if

//--- src/ats_rx_mem.sv
// Received-message memory with per-transmitter new-message flags
`timescale 1ns/1ns
module ats_rx_mem
  import ats_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic        wr_en,
  input  wire logic [2:0]  wr_chan,
  input  wire logic [7:0]  wr_label,
  input  wire logic [31:0] wr_word,
  ats_rx_if.mem            rx
);
  logic [31:0] msg  [0:(1<<RX_AW)-1];
  logic [3:0]  flag [0:(1<<RX_AW)-1];
  logic [RX_AW-1:0] wr_a;
  logic [RX_AW-1:0] rd_a;
  logic [7:0]  next_data;
  logic        next_flag;
  logic [7:0]  data_q;
  logic        flag_q;

  assign wr_a = {wr_chan, wr_label};
  assign rd_a = {rx.rd_chan, rx.rd_label};

  always_comb begin
    next_data = data_q;
    next_flag = flag_q;
    if (rx.rd_en) begin
      next_data = msg[rd_a][rx.rd_byte*8 +: 8];
      next_flag = flag[rd_a][rx.clr_tx];
    end
  end

  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      msg[wr_a] <= wr_word;
    end
  end

  // ==========================================================
  // Flags: a new message sets all, a fetch with clr_en clears its own; set wins
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < (1<<RX_AW); i++) begin
        flag[i] <= 4'h0;
      end
    end else begin
      if (rx.clr_en && !(wr_en && wr_a == rd_a)) begin
        flag[rd_a][rx.clr_tx] <= 1'b0;
      end
      if (wr_en) begin
        flag[wr_a] <= FLAGS_ALL;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      data_q <= 8'h00;
      flag_q <= 1'b0;
    end else begin
      data_q <= next_data;
      flag_q <= next_flag;
    end
  end

  assign rx.rd_data = data_q;
  assign rx.rd_flag = flag_q;
endmodule : ats_rx_mem

//--- src/ats_rep_timer.sv
// Repetition timer: shared base tick and one rate counter per transmitter
`timescale 1ns/1ns
module ats_rep_timer
  import ats_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = BASE_TICK_CYC
)(
  input  wire logic                          core_clk,
  input  wire logic                          rstn,
  input  wire logic                          run,
  input  wire logic                          run_rise,
  input  wire logic [NUM_TX-1:0][RATE_W-1:0] rate,
  output logic      [NUM_TX-1:0]             due
);
  logic [TICK_W-1:0] base;
  logic [TICK_W-1:0] next_base;
  logic              tick;

  // Free-running base tick, not tied to received traffic
  assign tick = run && (base == TICK_W'(TICK_CYCLES - 1));

  always_comb begin
    next_base = base + TICK_W'(1);
    if (!run || run_rise || tick) begin
      next_base = '0;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      base <= '0;
    end else begin
      base <= next_base;
    end
  end

  for (genvar c = 0; c < NUM_TX; c++) begin : g_chan
    logic [RATE_W-1:0] cnt;
    logic [RATE_W-1:0] next_cnt;
    logic              hit;

    // Rate zero never fires: one-time passes only
    assign hit    = tick && rate[c] != '0 && cnt == rate[c] - RATE_W'(1);
    assign due[c] = hit;

    always_comb begin
      next_cnt = cnt;
      if (!run || run_rise || hit) begin
        next_cnt = '0;
      end else if (tick) begin
        next_cnt = cnt + RATE_W'(1);
      end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
        cnt <= '0;
      end else begin
        cnt <= next_cnt;
      end
    end
  end
endmodule : ats_rep_timer

//--- src/ats_scheduler.sv
// Descriptor-driven transmit scheduler for four transmitters
`timescale 1ns/1ns
module ats_scheduler
  import ats_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = BASE_TICK_CYC
)(
  input  wire logic                          core_clk,
  input  wire logic                          rstn,
  input  wire logic                          run_pin,
  input  wire logic [NUM_TX-1:0]             tx_enable,
  input  wire logic [NUM_TX-1:0]             parity_en,
  input  wire logic [NUM_TX-1:0][RATE_W-1:0] rep_rate,
  input  wire logic                          host_wr_en,
  input  wire logic [15:0]                   host_wr_addr,
  input  wire logic [7:0]                    host_wr_data,
  input  wire logic                          rx_wr_en,
  input  wire logic [2:0]                    rx_wr_chan,
  input  wire logic [7:0]                    rx_wr_label,
  input  wire logic [31:0]                   rx_wr_word,
  output logic                               tx_valid,
  input  wire logic                          tx_ready,
  output logic      [1:0]                    tx_chan,
  output logic      [31:0]                   tx_word,
  output logic                               busy
);
  // ==========================================================
  // Run pin synchroniser and edge
  logic run_s1;
  logic run_s2;
  logic run_d;
  logic run;
  logic run_rise;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      run_s1 <= 1'b0;
      run_s2 <= 1'b0;
      run_d  <= 1'b0;
    end else begin
      run_s1 <= run_pin;
      run_s2 <= run_s1;
      run_d  <= run_s2;
    end
  end

  assign run      = run_s2;
  assign run_rise = run_s2 && !run_d;

  // ==========================================================
  // Descriptor table memory, byte index {chan, desc, byte, value}
  logic [7:0]        tbl [0:(1<<TBL_AW)-1];
  logic [TBL_AW-1:0] rd_idx;
  logic [7:0]        tbl_q;

  always_ff @(posedge core_clk) begin
    if (host_wr_en && host_wr_addr[15:TBL_AW] == TBL_REGION) begin
      tbl[host_wr_addr[TBL_AW-1:0]] <= host_wr_data;
    end
    tbl_q <= tbl[rd_idx];
  end

  // ==========================================================
  // Repetition timer and received-message memory
  logic [NUM_TX-1:0] due;
  ats_rx_if          rx ();

  ats_rep_timer #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_timer (
    .core_clk (core_clk),
    .rstn     (rstn),
    .run      (run),
    .run_rise (run_rise),
    .rate     (rep_rate),
    .due      (due)
  );

  ats_rx_mem u_rx_mem (
    .core_clk (core_clk),
    .rstn     (rstn),
    .wr_en    (rx_wr_en),
    .wr_chan  (rx_wr_chan),
    .wr_label (rx_wr_label),
    .wr_word  (rx_wr_word),
    .rx       (rx.mem)
  );

  // ==========================================================
  // Sequencer state
  ats_state_e        state;
  ats_state_e        next_state;
  logic [1:0]        ch;
  logic [1:0]        next_ch;
  logic [7:0]        ptr;
  logic [7:0]        next_ptr;
  logic [1:0]        bi;
  logic [1:0]        next_bi;
  logic [7:0]        act;
  logic [7:0]        next_act;
  logic [31:0]       word;
  logic [31:0]       next_word;
  logic              skip;
  logic              next_skip;
  logic              cond_done;
  logic              next_cond_done;
  logic [NUM_TX-1:0] pending;
  logic [NUM_TX-1:0] next_pending;
  logic [NUM_TX-1:0] taken;
  logic [1:0]        pick;
  logic [2:0]        cls;
  logic              adv;
  logic [7:0]        byte_v;

  assign cls = act[7:ACT_CLS_LSB];

  always_comb begin
    pick = 2'h0;
    for (int i = NUM_TX - 1; i >= 0; i--) begin
      if (pending[i]) begin
        pick = 2'(i);
      end
    end
  end

  always_comb begin
    next_state     = state;
    next_ch        = ch;
    next_ptr       = ptr;
    next_bi        = bi;
    next_act       = act;
    next_word      = word;
    next_skip      = skip;
    next_cond_done = cond_done;
    taken          = '0;
    adv            = 1'b0;
    byte_v         = 8'h00;
    rd_idx         = {ch, ptr, bi, 1'b0};
    rx.rd_en       = 1'b0;
    rx.rd_chan     = act[ACT_CLS_LSB-1:ACT_RXC_LSB];
    rx.rd_label    = tbl_q;
    rx.rd_byte     = act[1:0];
    rx.clr_en      = 1'b0;
    rx.clr_tx      = ch;
    tx_valid       = 1'b0;
    case (state)
      ATS_IDLE: begin
        if (|pending) begin
          next_ch        = pick;
          next_ptr       = '0;
          next_bi        = '0;
          next_skip      = 1'b0;
          next_cond_done = 1'b0;
          taken[pick]    = 1'b1;
          next_state     = ATS_FETCH_A;
        end
      end
      ATS_FETCH_A: begin
        next_state = ATS_GOT_A;
      end
      ATS_GOT_A: begin
        next_act = tbl_q;
        if (bi == 2'h0 && tbl_q == ACT_EOS) begin
          next_state = ATS_IDLE;
        end else begin
          rd_idx     = {ch, ptr, bi, 1'b1};
          next_state = ATS_GOT_V;
        end
      end
      ATS_GOT_V: begin
        case (cls)
          CLS_IMM: begin
            byte_v = tbl_q;
            adv    = 1'b1;
          end
          CLS_IDX, CLS_IDC, CLS_IDC_PEEK: begin
            rx.rd_en   = 1'b1;
            rx.clr_en  = (cls == CLS_IDC);
            next_state = ATS_GOT_R;
          end
          default: begin
            byte_v = 8'h00;
            adv    = 1'b1;
          end
        endcase
      end
      ATS_GOT_R: begin
        byte_v = rx.rd_data;
        adv    = 1'b1;
        if ((cls == CLS_IDC || cls == CLS_IDC_PEEK) && !cond_done) begin
          next_cond_done = 1'b1;
          next_skip      = !rx.rd_flag;
        end
      end
      ATS_SEND: begin
        tx_valid = !skip;
        if (skip || tx_ready) begin
          next_bi        = '0;
          next_skip      = 1'b0;
          next_cond_done = 1'b0;
          if (ptr == DESC_LAST) begin
            next_state = ATS_IDLE;
          end else begin
            next_ptr   = ptr + 8'h01;
            next_state = ATS_FETCH_A;
          end
        end
      end
      default: begin
        next_state = ATS_IDLE;
      end
    endcase
    if (adv) begin
      if (bi == BYTE_LAST && parity_en[ch]) begin
        byte_v[7] = ~^{byte_v[6:0], word[23:0]};
      end
      next_word[bi*8 +: 8] = byte_v;
      if (bi == BYTE_LAST) begin
        next_state = ATS_SEND;
      end else begin
        next_bi    = bi + 2'h1;
        next_state = ATS_FETCH_A;
      end
    end
    if (!run) begin
      next_state = ATS_IDLE;
    end
  end

  // Passes queue per table; a new due beats a same-cycle take
  always_comb begin
    next_pending = (pending & ~taken) | due;
    if (run_rise) begin
      next_pending = next_pending | tx_enable;
    end
    next_pending = next_pending & tx_enable;
    if (!run) begin
      next_pending = '0;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state     <= ATS_IDLE;
      ch        <= 2'h0;
      ptr       <= 8'h00;
      bi        <= 2'h0;
      act       <= 8'h00;
      word      <= 32'h0000_0000;
      skip      <= 1'b0;
      cond_done <= 1'b0;
      pending   <= '0;
    end else begin
      state     <= next_state;
      ch        <= next_ch;
      ptr       <= next_ptr;
      bi        <= next_bi;
      act       <= next_act;
      word      <= next_word;
      skip      <= next_skip;
      cond_done <= next_cond_done;
      pending   <= next_pending;
    end
  end

  assign tx_chan = ch;
  assign tx_word = word;
  assign busy    = (state != ATS_IDLE);
endmodule : ats_scheduler

//--- sim/ats_line_model.sv
// Line driver stand-in that takes words after a programmable stall
`timescale 1ns/1ns
module ats_line_model (
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic        tx_valid,
  input  wire logic [1:0]  tx_chan,
  input  wire logic [31:0] tx_word,
  input  wire logic [7:0]  stall,
  output logic             tx_ready
);
  logic [7:0]  wait_cnt;
  int          cyc;
  logic [33:0] q[$];
  int          ts[$];

  // Ready only once the offered word has waited the stall count
  assign tx_ready = tx_valid && (wait_cnt == stall);

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wait_cnt <= '0;
      cyc      <= 0;
    end else begin
      cyc <= cyc + 1;
      if (tx_valid && tx_ready) begin
        q.push_back({tx_chan, tx_word});
        ts.push_back(cyc);
        wait_cnt <= '0;
      end else if (tx_valid) begin
        wait_cnt <= wait_cnt + 8'h01;
      end else begin
        wait_cnt <= '0;
      end
    end
  end
endmodule : ats_line_model

//--- sim/ats_scheduler_sva.sv
// Port checker for the transmit scheduler
`timescale 1ns/1ns
module ats_scheduler_sva
  import ats_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = BASE_TICK_CYC
)(
  input wire logic                          core_clk,
  input wire logic                          rstn,
  input wire logic                          run_pin,
  input wire logic [NUM_TX-1:0]             tx_enable,
  input wire logic [NUM_TX-1:0]             parity_en,
  input wire logic [NUM_TX-1:0][RATE_W-1:0] rep_rate,
  input wire logic                          tx_valid,
  input wire logic                          tx_ready,
  input wire logic [1:0]                    tx_chan,
  input wire logic [31:0]                   tx_word,
  input wire logic                          busy
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // ==========================================================
  // Sequences
  sequence s_run_steady;
    run_pin [*4];
  endsequence
  sequence s_handoff;
    tx_valid && tx_ready;
  endsequence
  // ==========================================================
  // Properties
  property p_valid_busy;
    tx_valid |-> busy;
  endproperty
  a_valid_busy: assert property (p_valid_busy) else $error("valid while idle");
  property p_hold;
    s_run_steady ##0 (tx_valid && !tx_ready) |=> tx_valid && $stable(tx_word) && $stable(tx_chan);
  endproperty
  a_hold: assert property (p_hold) else $error("offered word dropped");
  property p_stop;
    !run_pin [*5] |-> !tx_valid && !busy;
  endproperty
  a_stop: assert property (p_stop) else $error("active with run low");
  property p_parity;
    tx_valid && parity_en[tx_chan] |-> ^tx_word;
  endproperty
  a_parity: assert property (p_parity) else $error("parity not odd");
  property p_chan_en;
    tx_valid |-> tx_enable[tx_chan];
  endproperty
  a_chan_en: assert property (p_chan_en) else $error("disabled channel sent");
  property p_start;
    $rose(run_pin) && |tx_enable |-> ##[2:8] busy;
  endproperty
  a_start: assert property (p_start) else $error("no start after run");
  property p_one_time;
    (rep_rate == '0 && run_pin && !busy) [*6] |=> !busy;
  endproperty
  a_one_time: assert property (p_one_time) else $error("repeat in one-time mode");
  property p_spacing;
    s_handoff |=> !tx_valid [*8];
  endproperty
  a_spacing: assert property (p_spacing) else $error("word too soon");
endmodule : ats_scheduler_sva

bind ats_scheduler ats_scheduler_sva #(.TICK_CYCLES(TICK_CYCLES)) u_sva (
  .core_clk(core_clk), .rstn(rstn), .run_pin(run_pin), .tx_enable(tx_enable),
  .parity_en(parity_en), .rep_rate(rep_rate), .tx_valid(tx_valid), .tx_ready(tx_ready),
  .tx_chan(tx_chan), .tx_word(tx_word), .busy(busy)
);

//--- sim/ats_scheduler_bench.sv
// Self-checking bench for the transmit scheduler
`timescale 1ns/1ns
module ats_scheduler_bench
  import ats_pkg::*;
;
  localparam int unsigned TICKS = 20;
  logic                          core_clk     = 1'b0;
  logic                          rstn         = 1'b0;
  logic                          run_pin      = 1'b0;
  logic [NUM_TX-1:0]             tx_enable    = '0;
  logic [NUM_TX-1:0]             parity_en    = '0;
  logic [NUM_TX-1:0][RATE_W-1:0] rep_rate     = '0;
  logic                          host_wr_en   = 1'b0;
  logic [15:0]                   host_wr_addr = '0;
  logic [7:0]                    host_wr_data = '0;
  logic                          rx_wr_en     = 1'b0;
  logic [2:0]                    rx_wr_chan   = '0;
  logic [7:0]                    rx_wr_label  = '0;
  logic [31:0]                   rx_wr_word   = '0;
  logic [7:0]                    stall        = '0;
  logic                          tx_valid;
  logic                          tx_ready;
  logic                          busy;
  logic [1:0]                    tx_chan;
  logic [31:0]                   tx_word;
  int                            error_cnt    = 0;
  int                            compares     = 0;
  int                            last_t       = 0;

  always #4 core_clk = ~core_clk;

  ats_scheduler #(.TICK_CYCLES(TICKS)) dut (
    .core_clk(core_clk), .rstn(rstn), .run_pin(run_pin), .tx_enable(tx_enable),
    .parity_en(parity_en), .rep_rate(rep_rate), .host_wr_en(host_wr_en),
    .host_wr_addr(host_wr_addr), .host_wr_data(host_wr_data), .rx_wr_en(rx_wr_en),
    .rx_wr_chan(rx_wr_chan), .rx_wr_label(rx_wr_label), .rx_wr_word(rx_wr_word),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_chan(tx_chan), .tx_word(tx_word),
    .busy(busy)
  );
  ats_line_model line (
    .core_clk(core_clk), .rstn(rstn), .tx_valid(tx_valid), .tx_chan(tx_chan),
    .tx_word(tx_word), .stall(stall), .tx_ready(tx_ready)
  );

  // ==========================================================
  // Helpers
  task automatic summarize();
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : summarize
  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : step
  function automatic logic [15:0] da(input int c, input int d);
    return TBL_BASE + 16'(c * 2048 + d * 8);
  endfunction : da
  function automatic logic [31:0] par(input logic [31:0] w);
    return {~^w[30:0], w[30:0]};
  endfunction : par
  // Writes one descriptor, action and value bytes alternating
  task automatic wr(input logic [15:0] a, input logic [63:0] av);
    for (int i = 0; i < 8; i++) begin
      host_wr_en = 1'b1;
      host_wr_addr = a + 16'(i);
      host_wr_data = av[63-8*i -: 8];
      step(1);
    end
    host_wr_en = 1'b0;
    step(1);
  endtask : wr
  task automatic get(input logic [33:0] exp);
    int n = 0;
    while (line.q.size() == 0 && n < 500) begin
      step(1);
      n++;
    end
    if (line.q.size() == 0) begin
      chk('x, exp);
    end else begin
      last_t = line.ts.pop_front();
      chk(line.q.pop_front(), exp);
    end
  endtask : get
  task automatic none();
    step(80);
    chk(34'(line.q.size()), '0);
  endtask : none

  // ==========================================================
  // Scenarios
  task automatic t_imm();
    parity_en = 4'h1;
    tx_enable = 4'h1;
    wr(da(0, 0), 64'h40_11_40_22_40_33_40_84);
    wr(da(0, 1), 64'h40_12_40_22_40_33_40_04);
    wr(da(0, 2), '0);
    for (int r = 0; r < 2; r++) begin
      stall = 8'(r * 5);
      run_pin = 1'b1;
      get({2'd0, par(32'h84332211)});
      get({2'd0, par(32'h04332212)});
      none();
      run_pin = 1'b0;
      step(8);
    end
  endtask : t_imm
  task automatic t_rep();
    int ta;
    parity_en = 4'h0;
    rep_rate[0] = 8'd3;
    run_pin = 1'b1;
    get({2'd0, 32'h84332211});
    get({2'd0, 32'h04332212});
    get({2'd0, 32'h84332211});
    ta = last_t;
    get({2'd0, 32'h04332212});
    get({2'd0, 32'h84332211});
    chk(34'(last_t - ta), 34'(3 * TICKS));
    run_pin = 1'b0;
    none();
    rep_rate = '0;
  endtask : t_rep
  task automatic t_idx();
    tx_enable = 4'h6;
    wr(da(1, 0), 64'h40_5a_a1_00_a2_00_a3_00);
    wr(da(1, 1), '0);
    wr(da(2, 0), 64'h20_77_81_00_c2_00_60_99);
    wr(da(2, 1), '0);
    rx_wr_en = 1'b1;
    rx_wr_word = 32'h56340200;
    step(1);
    rx_wr_en = 1'b0;
    for (int r = 0; r < 2; r++) begin
      run_pin = 1'b1;
      if (r == 0) begin
        get({2'd1, 32'h5634025a});
      end
      get({2'd2, 32'h00340200});
      none();
      run_pin = 1'b0;
      step(8);
    end
  endtask : t_idx
  task automatic t_abort();
    tx_enable = 4'h1;
    stall = 8'hff;
    run_pin = 1'b1;
    step(40);
    chk({33'h0, tx_valid}, 34'h1);
    chk({33'h0, busy}, 34'h1);
    run_pin = 1'b0;
    step(6);
    chk({33'h0, tx_valid}, 34'h0);
    chk({33'h0, busy}, 34'h0);
    stall = 8'h00;
    none();
  endtask : t_abort

  // ==========================================================
  // Main sequence and watchdog
  initial begin
    step(3);
    rstn = 1'b1;
    step(1);
    t_imm();
    t_rep();
    t_idx();
    t_abort();
    summarize();
  end
  initial begin
    #(20000 * 8);
    error_cnt++;
    summarize();
  end
endmodule : ats_scheduler_bench
